/* logic/qac_pkg.sv */
// Constants and types shared by the converter channel configuration register bank
`default_nettype none
package qac_pkg;
   localparam int NUM_CHANNELS = 4;
   localparam logic [7:0] ADDR_CHAN_SEL = 8'h05;
   localparam logic [7:0] ADDR_MODES = 8'h08;
   localparam logic [7:0] ADDR_CLOCK = 8'h09;
   localparam logic [7:0] ADDR_TEST = 8'h0d;
   localparam logic [7:0] ADDR_BIST = 8'h0e;
   localparam logic [7:0] ADDR_INPUT = 8'h0f;
   localparam logic [7:0] ADDR_COMMIT = 8'hff;
   localparam logic [7:0] RST_CHAN_SEL = 8'h0f;
   localparam logic [7:0] RST_MODES = 8'h00;
   localparam logic [7:0] RST_CLOCK = 8'h01;
   localparam logic [7:0] RST_TEST = 8'h00;
   localparam logic [7:0] RST_BIST = 8'h00;
   localparam logic [7:0] RST_INPUT = 8'h00;
   localparam logic [7:0] RST_COMMIT = 8'h00;
   // Writable bits; all others are reserved and read as zero
   localparam logic [7:0] MASK_CHAN_SEL = 8'h0f;
   localparam logic [7:0] MASK_MODES = 8'h63;
   localparam logic [7:0] MASK_CLOCK = 8'h01;
   localparam logic [7:0] MASK_TEST = 8'h3f;
   localparam logic [7:0] MASK_BIST = 8'h05;
   localparam logic [7:0] MASK_INPUT = 8'h06;
   localparam logic [7:0] MASK_COMMIT = 8'h01;
   localparam int PWR_LSB = 0;
   localparam int EXT_PD_LSB = 5;
   localparam int DCS_BIT = 0;
   localparam int PATTERN_LSB = 0;
   localparam int PN_SHORT_BIT = 4;
   localparam int PN_LONG_BIT = 5;
   localparam int BIST_EN_BIT = 0;
   localparam int BIST_INIT_BIT = 2;
   localparam int VCM_EN_BIT = 1;
   localparam int ANA_DISC_BIT = 2;
   localparam int COMMIT_BIT = 0;
   localparam logic [1:0] PWR_CODE_RUN = 2'h0;
   localparam logic [1:0] PWR_CODE_DOWN = 2'h1;
   localparam logic [1:0] PWR_CODE_STANDBY = 2'h2;
   localparam logic [1:0] PWR_CODE_RESET = 2'h3;

   typedef enum logic [3:0] {
      qac_pwr_run = 4'h1,
      qac_pwr_down = 4'h2,
      qac_pwr_standby = 4'h4,
      qac_pwr_reset = 4'h8
   } qac_pwr_e;
endpackage
`default_nettype wire

/* logic/qac_chan_if.sv */
// Carrier between the register bank and one channel slice
`timescale 1ns/100ps
`default_nettype none
interface qac_chan_if;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic commit;
   logic [7:0] pend_modes;
   logic [7:0] pend_test;
   logic [7:0] pend_bist;
   logic [7:0] pend_input;
   logic [7:0] act_modes;
   logic [7:0] act_test;
   logic [7:0] act_bist;
   logic [7:0] act_input;
   qac_pkg::qac_pwr_e pwr;
   modport bank (output wr, addr, wdata, commit,
      input pend_modes, pend_test, pend_bist, pend_input,
      input act_modes, act_test, act_bist, act_input, pwr);
   modport slice (input wr, addr, wdata, commit,
      output pend_modes, pend_test, pend_bist, pend_input,
      output act_modes, act_test, act_bist, act_input, pwr);
endinterface
`default_nettype wire

/* logic/qac_chan_slice.sv */
// Per-channel pending and active function registers with power state
`timescale 1ns/100ps
`default_nettype none
module qac_chan_slice (
   input wire logic clock,
   input wire logic resetn,
   qac_chan_if.slice ch
);
   // Pending copies take host writes steered to this channel
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ch.pend_modes <= qac_pkg::RST_MODES; // see (RL6)
         ch.pend_test <= qac_pkg::RST_TEST;
         ch.pend_bist <= qac_pkg::RST_BIST;
         ch.pend_input <= qac_pkg::RST_INPUT;
      end else if (ch.wr) begin // see (RL1)
         case (ch.addr)
            qac_pkg::ADDR_MODES: ch.pend_modes <= ch.wdata & qac_pkg::MASK_MODES;
            qac_pkg::ADDR_TEST: ch.pend_test <= ch.wdata & qac_pkg::MASK_TEST;
            qac_pkg::ADDR_BIST: ch.pend_bist <= ch.wdata & qac_pkg::MASK_BIST;
            qac_pkg::ADDR_INPUT: ch.pend_input <= ch.wdata & qac_pkg::MASK_INPUT;
            default: ;
         endcase
      end
   end

   // Active copies change only together on commit
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ch.act_modes <= qac_pkg::RST_MODES;
         ch.act_test <= qac_pkg::RST_TEST;
         ch.act_bist <= qac_pkg::RST_BIST;
         ch.act_input <= qac_pkg::RST_INPUT;
      end else if (ch.commit) begin // see (RL8)
         ch.act_modes <= ch.pend_modes;
         ch.act_test <= ch.pend_test;
         ch.act_bist <= ch.pend_bist;
         ch.act_input <= ch.pend_input;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ch.pwr <= qac_pkg::qac_pwr_run; // see (RL3)
      end else if (ch.commit) begin
         case (ch.pend_modes[qac_pkg::PWR_LSB +: 2]) // see (RL3)
            qac_pkg::PWR_CODE_RUN: ch.pwr <= qac_pkg::qac_pwr_run;
            qac_pkg::PWR_CODE_DOWN: ch.pwr <= qac_pkg::qac_pwr_down;
            qac_pkg::PWR_CODE_STANDBY: ch.pwr <= qac_pkg::qac_pwr_standby;
            qac_pkg::PWR_CODE_RESET: ch.pwr <= qac_pkg::qac_pwr_reset;
            default: ch.pwr <= qac_pkg::qac_pwr_run;
         endcase
      end
   end
endmodule // qac_chan_slice
`default_nettype wire

/* logic/qac_config_regs.sv */
// Channel select and converter function configuration register bank
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// (RL1) One select bit per channel; only selected channels take the next register write.
// (RL2) Select register resets to all four channels enabled.
// (RL3) Power field: 00 run, 01 full power-down, 10 standby, 11 channel reset.
// (RL4) Clock register bit 0 set enables the duty cycle stabilizer, clear bypasses it.
// (RL5) Stabilizer control bit reads one after reset.
// (RL6) Registers hold their defaults at reset before any host access is taken.
// (RL7) Host writes zeros to reserved bits and only defaults to undefined addresses.
// (RL8) Shadowed fields apply together when commit bit is set; device then clears it.
module qac_config_regs #(
   parameter int NCH = qac_pkg::NUM_CHANNELS
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_ready,
   output logic dcs_enable,
   output logic [NCH-1:0] chan_run,
   output logic [NCH-1:0] chan_powerdown,
   output logic [NCH-1:0] chan_standby,
   output logic [NCH-1:0] chan_reset,
   output logic [2*NCH-1:0] ext_pd_function,
   output logic [4*NCH-1:0] test_pattern,
   output logic [NCH-1:0] pn_short_reset,
   output logic [NCH-1:0] pn_long_reset,
   output logic [NCH-1:0] bist_enable,
   output logic [NCH-1:0] bist_init,
   output logic [NCH-1:0] vcm_enable,
   output logic [NCH-1:0] analog_disconnect
);
   logic [7:0] channel_select;
   logic [7:0] pend_clock;
   logic [7:0] act_clock;
   logic commit_bit;
   logic wr_ok;
   logic [7:0] next_rdata;
   logic [7:0] pm [NCH];
   logic [7:0] pt [NCH];
   logic [7:0] pb [NCH];
   logic [7:0] pi [NCH];

   // Channel A sits on the highest select bit
   function automatic int sel_bit(input int idx);
      return NCH - 1 - idx;
   endfunction

   // Reads of per-channel registers come from the first selected channel
   function automatic int first_sel(input logic [7:0] sel);
      int r;
      r = -1;
      for (int k = NCH - 1; k >= 0; k--) begin
         if (sel[sel_bit(k)]) begin
            r = k;
         end
      end
      return r;
   endfunction

   // Accesses are refused until defaults have settled
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_ready <= 1'b0;
      end else begin
         reg_ready <= 1'b1; // see (RL6)
      end
   end

   assign wr_ok = reg_wr & reg_ready; // see (RL6)

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         channel_select <= qac_pkg::RST_CHAN_SEL; // see (RL2)
      end else if (wr_ok && reg_addr == qac_pkg::ADDR_CHAN_SEL) begin
         channel_select <= reg_wdata & qac_pkg::MASK_CHAN_SEL; // see (RL1)
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pend_clock <= qac_pkg::RST_CLOCK; // see (RL5)
      end else if (wr_ok && reg_addr == qac_pkg::ADDR_CLOCK) begin
         pend_clock <= reg_wdata & qac_pkg::MASK_CLOCK;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         act_clock <= qac_pkg::RST_CLOCK; // see (RL5)
      end else if (commit_bit) begin
         act_clock <= pend_clock; // see (RL8)
      end
   end

   // A fresh host write in the commit cycle wins over the self-clear
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         commit_bit <= qac_pkg::RST_COMMIT[qac_pkg::COMMIT_BIT];
      end else if (wr_ok && reg_addr == qac_pkg::ADDR_COMMIT) begin
         commit_bit <= reg_wdata[qac_pkg::COMMIT_BIT]; // see (RL8)
      end else if (commit_bit) begin
         commit_bit <= 1'b0; // see (RL8)
      end
   end

   assign dcs_enable = act_clock[qac_pkg::DCS_BIT]; // see (RL4)

   for (genvar i = 0; i < NCH; i++) begin : g_chan
      qac_chan_if ch ();
      assign ch.wr = wr_ok & channel_select[sel_bit(i)]; // see (RL1)
      assign ch.addr = reg_addr;
      assign ch.wdata = reg_wdata;
      assign ch.commit = commit_bit; // see (RL8)
      assign pm[i] = ch.pend_modes;
      assign pt[i] = ch.pend_test;
      assign pb[i] = ch.pend_bist;
      assign pi[i] = ch.pend_input;
      assign chan_run[i] = ch.pwr == qac_pkg::qac_pwr_run; // see (RL3)
      assign chan_powerdown[i] = ch.pwr == qac_pkg::qac_pwr_down;
      assign chan_standby[i] = ch.pwr == qac_pkg::qac_pwr_standby;
      assign chan_reset[i] = ch.pwr == qac_pkg::qac_pwr_reset;
      assign ext_pd_function[2*i +: 2] = ch.act_modes[qac_pkg::EXT_PD_LSB +: 2];
      assign test_pattern[4*i +: 4] = ch.act_test[qac_pkg::PATTERN_LSB +: 4];
      assign pn_short_reset[i] = ch.act_test[qac_pkg::PN_SHORT_BIT];
      assign pn_long_reset[i] = ch.act_test[qac_pkg::PN_LONG_BIT];
      assign bist_enable[i] = ch.act_bist[qac_pkg::BIST_EN_BIT];
      assign bist_init[i] = ch.act_bist[qac_pkg::BIST_INIT_BIT];
      assign vcm_enable[i] = ch.act_input[qac_pkg::VCM_EN_BIT];
      assign analog_disconnect[i] = ch.act_input[qac_pkg::ANA_DISC_BIT];
      qac_chan_slice u_slice (
         .clock(clock),
         .resetn(resetn),
         .ch(ch)
      );
   end

   // Read value; unmapped addresses and reserved bits read zero
   always_comb begin
      int f;
      f = first_sel(channel_select);
      next_rdata = 8'h00;
      case (reg_addr)
         qac_pkg::ADDR_CHAN_SEL: next_rdata = channel_select;
         qac_pkg::ADDR_CLOCK: next_rdata = pend_clock; // see (RL5)
         qac_pkg::ADDR_COMMIT: next_rdata = {7'h00, commit_bit};
         qac_pkg::ADDR_MODES: next_rdata = (f >= 0) ? pm[f] : 8'h00;
         qac_pkg::ADDR_TEST: next_rdata = (f >= 0) ? pt[f] : 8'h00;
         qac_pkg::ADDR_BIST: next_rdata = (f >= 0) ? pb[f] : 8'h00;
         qac_pkg::ADDR_INPUT: next_rdata = (f >= 0) ? pi[f] : 8'h00;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd & reg_ready;
         if (reg_rd && reg_ready) begin
            reg_rdata <= next_rdata;
         end
      end
   end
endmodule // qac_config_regs
`default_nettype wire

/* bench/qac_config_regs_chk.sv */
// Port-level property checker for the channel configuration register bank
`timescale 1ns/100ps
`default_nettype none
module qac_config_regs_chk #(
   parameter int NCH = 4
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic reg_ready,
   input wire logic dcs_enable,
   input wire logic [NCH-1:0] chan_run,
   input wire logic [NCH-1:0] chan_powerdown,
   input wire logic [NCH-1:0] chan_standby,
   input wire logic [NCH-1:0] chan_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic commit_wr;
   logic rd_ok;
   assign commit_wr = reg_wr && reg_ready && reg_addr == 8'hff && reg_wdata[0];
   assign rd_ok = reg_rd && reg_ready;
   property p_ready_rel; $rose(resetn) |-> !reg_ready ##1 reg_ready; endproperty
   a_ready_rel: assert property (p_ready_rel) else $error("ready late");
   property p_dflt; $rose(reg_ready) |-> dcs_enable && chan_run == {NCH{1'b1}}; endproperty
   a_dflt: assert property (p_dflt) else $error("bad defaults");
   property p_rvalid; rd_ok |=> reg_rvalid; endproperty
   a_rvalid: assert property (p_rvalid) else $error("no read answer");
   property p_hold; !rd_ok |=> $stable(reg_rdata) && !reg_rvalid; endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_unmap; rd_ok && reg_addr == 8'h40 |=> reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_selres; rd_ok && reg_addr == 8'h05 |=> reg_rdata[7:4] == 4'h0; endproperty
   a_selres: assert property (p_selres) else $error("select reserved");
   property p_dcs; $changed(dcs_enable) |-> $past(commit_wr, 2); endproperty
   a_dcs: assert property (p_dcs) else $error("clock without commit");
   property p_run; $changed(chan_run) |-> $past(commit_wr, 2); endproperty
   a_run: assert property (p_run) else $error("mode without commit");
   property p_onehot;
      (chan_run | chan_powerdown | chan_standby | chan_reset) == {NCH{1'b1}} &&
      (chan_run ^ chan_powerdown ^ chan_standby ^ chan_reset) == {NCH{1'b1}} &&
      ((chan_run & chan_powerdown) | (chan_standby & chan_reset)) == {NCH{1'b0}};
   endproperty
   a_onehot: assert property (p_onehot) else $error("power state");
endmodule // qac_config_regs_chk
bind qac_config_regs qac_config_regs_chk #(.NCH(NCH)) qac_config_regs_chk_inst (.clock, .resetn,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .reg_ready, .dcs_enable,
   .chan_run, .chan_powerdown, .chan_standby, .chan_reset);
`default_nettype wire

/* bench/qac_host.sv */
// Host model driving the parallel register port
`timescale 1ns/100ps
`default_nettype none
module qac_host (
   input wire logic clock,
   input wire logic reg_ready,
   input wire logic reg_rvalid,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic wait_ready();
      @(negedge clock);
      while (!reg_ready) @(negedge clock);
   endtask
   // Only legal values are sent: reserved bits zero, undefined addresses never written
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wait_ready();
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      wait_ready();
      reg_addr = a;
      reg_rd = 1'b1;
      // Read answer stands for the one cycle after the accepting edge
      @(negedge clock);
      d = reg_rvalid ? reg_rdata : 8'hxx;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
   task automatic commit();
      wr(8'hff, 8'h01);
   endtask
endmodule // qac_host
`default_nettype wire

/* bench/qac_config_regs_tb.sv */
// Self-checking testbench for the channel configuration register bank
`timescale 1ns/100ps
`default_nettype none
module qac_config_regs_tb;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, reg_ready, dcs_enable;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, ext_pd_function;
   logic [3:0] chan_run, chan_powerdown, chan_standby, chan_reset, pn_short_reset, pn_long_reset;
   logic [3:0] bist_enable, bist_init, vcm_enable, analog_disconnect;
   logic [15:0] test_pattern, pwr;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   assign pwr = {chan_reset, chan_standby, chan_powerdown, chan_run};
   always #5 clock = ~clock;
   qac_config_regs qac_config_regs_inst (.clock, .resetn, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_rvalid, .reg_ready, .dcs_enable, .chan_run, .chan_powerdown,
      .chan_standby, .chan_reset, .ext_pd_function, .test_pattern, .pn_short_reset,
      .pn_long_reset, .bist_enable, .bist_init, .vcm_enable, .analog_disconnect);
   qac_host qac_host_inst (.clock, .reg_ready, .reg_rvalid, .reg_rdata, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata);
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic do_reset();
      resetn = 1'b0;
      repeat (2) @(negedge clock);
      resetn = 1'b1;
   endtask
   task automatic t_defaults();
      logic [7:0] adr[8] = '{8'h05, 8'h08, 8'h09, 8'h0d, 8'h0e, 8'h0f, 8'hff, 8'h40};
      logic [7:0] dft[8] = '{8'h0f, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      check("dcs", dcs_enable, 16'h1);
      check("pwr", pwr, 16'h000f);
      check("pattern_dflt", test_pattern, 16'h0000);
      check("fn_dflt", {ext_pd_function, pn_long_reset, pn_short_reset}, 16'h0000);
      check("fn2_dflt", {bist_enable, bist_init, vcm_enable, analog_disconnect}, 16'h0000);
      foreach (adr[i]) begin
         qac_host_inst.rd(adr[i], rv);
         check("reg", rv, dft[i]);
      end
   endtask
   task automatic t_modes();
      int codes[4] = '{1, 2, 3, 0};
      int prev = 0;
      foreach (codes[k]) begin
         qac_host_inst.wr(8'h08, 8'(codes[k]));
         check("pwr_held", pwr, 16'hf << (4 * prev));
         qac_host_inst.commit();
         @(negedge clock);
         check("pwr", pwr, 16'hf << (4 * codes[k]));
         prev = codes[k];
      end
      qac_host_inst.rd(8'hff, rv);
      check("commit_clr", rv, 8'h00);
   endtask
   task automatic t_select();
      qac_host_inst.wr(8'h05, 8'h08);
      qac_host_inst.wr(8'h08, 8'h01);
      qac_host_inst.commit();
      @(negedge clock);
      check("sel_a", pwr, 16'h001e);
      qac_host_inst.wr(8'h05, 8'h00);
      qac_host_inst.wr(8'h08, 8'h02);
      qac_host_inst.rd(8'h08, rv);
      check("sel_none", rv, 8'h00);
      qac_host_inst.wr(8'h05, 8'h09);
      qac_host_inst.rd(8'h08, rv);
      check("sel_rd", rv, 8'h01);
      qac_host_inst.commit();
      @(negedge clock);
      check("sel_drop", pwr, 16'h001e);
      qac_host_inst.wr(8'h05, 8'h0f);
      qac_host_inst.wr(8'h08, 8'h00);
      qac_host_inst.commit();
   endtask
   task automatic t_clock();
      qac_host_inst.wr(8'h09, 8'h00);
      check("dcs_held", dcs_enable, 16'h1);
      qac_host_inst.commit();
      @(negedge clock);
      check("dcs_off", dcs_enable, 16'h0);
      qac_host_inst.wr(8'h09, 8'h01);
      qac_host_inst.commit();
      @(negedge clock);
      check("dcs_on", dcs_enable, 16'h1);
   endtask
   task automatic t_funcs();
      qac_host_inst.wr(8'h08, 8'h40);
      qac_host_inst.wr(8'h0d, 8'h25);
      qac_host_inst.wr(8'h0e, 8'h05);
      qac_host_inst.wr(8'h0f, 8'h06);
      qac_host_inst.commit();
      @(negedge clock);
      check("ext_pd", ext_pd_function, 16'h00aa);
      check("pattern", test_pattern, 16'h5555);
      check("pn_bist", {pn_long_reset, pn_short_reset, bist_init, bist_enable}, 16'hf0ff);
      check("input", {vcm_enable, analog_disconnect}, 16'h00ff);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      do_reset();
      t_defaults();
      t_modes();
      t_select();
      t_clock();
      t_funcs();
      do_reset();
      t_defaults();
      print_verdict();
   end
endmodule // qac_config_regs_tb
`default_nettype wire
